//--- shared/ppd_pkg.sv
// Constants and state type for the programmable divider of the synthesizer
// Functional notes
// - Divider, reference and phase outputs run only while chip-enable pin is high.
// - On start, load data registers and swallow low bit into both counters.
// - When programmable counter reaches zero, reload both counters from data registers.
// - Data written while running takes effect at the next reload or the next mode-register write.
// - Division data registers keep contents through reset; no defined power-on value.
// - Swallow counter is 5-bit down counter for FM; programmable is 12-bit.
// - Counters start together; 1/33 while swallow nonzero, then halt and 1/32.
// - Direct uses upper 12 data bits; swallow mode uses all 16 bits.
// - Swallow low bit is the least significant bit of swallow counter.
// - Ratio is N direct, N times 32 plus M in swallow mode.
// - Reference divides 4.5 MHz crystal to one of ten selected frequencies.
// - Method 0 uses AM input, pulls FM low; 1 uses FM, pulls AM low.
// - Enable bit 1 starts the synthesizer, 0 stops it.
// - IF-counter interrupt has enable and pending; pending cleared by writing 0.
// - Chip-enable interrupt has enable gating requests and pending cleared by writing 0.
// - Operation begins when software writes the mode register; a chip-enable rise also restarts it while the enable bit stays set.
package ppd_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [2:0] PPD_A_MODE = 3'h0;
   localparam logic [2:0] PPD_A_DLO = 3'h1;
   localparam logic [2:0] PPD_A_DHI = 3'h2;
   localparam logic [2:0] PPD_A_RSEL = 3'h3;
   localparam logic [2:0] PPD_A_STS = 3'h4;
   localparam logic [2:0] PPD_A_MSK = 3'h5;
   // ----------------------------------------
   // Mode register fields
   // ----------------------------------------
   localparam int PPD_MB_METHOD = 7;
   localparam int PPD_MB_ENABLE = 6;
   localparam int PPD_MB_NF = 5;
   localparam int PPD_MB_IFEN = 3;
   localparam int PPD_MB_IFPND = 2;
   localparam int PPD_MB_CEEN = 1;
   localparam int PPD_MB_CEPND = 0;
   // ----------------------------------------
   // Status and mask fields, and the chip-enable level bit of the reference-select read
   // ----------------------------------------
   localparam int PPD_SB_CEFALL = 0;
   localparam int PPD_SB_IFC = 1;
   localparam int PPD_SB_CERISE = 2;
   localparam int PPD_RB_CELVL = 4;
   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [7:0] PPD_MODE_RST = 8'h00;
   localparam logic [3:0] PPD_RSEL_RST = 4'h0;
   localparam logic [2:0] PPD_MSK_RST = 3'h0;
   localparam logic [5:0] PPD_PRE_LAST32 = 6'h1F;
   localparam logic [5:0] PPD_PRE_LAST33 = 6'h20;

   typedef enum logic [0:0] {
      PPD_IDLE = 1'b0,
      PPD_RUN = 1'b1
   } ppd_run_t;

   typedef struct packed {
      ppd_run_t run;
      logic [7:0] mode;
      logic [7:0] dlo;
      logic [7:0] dhi;
      logic [3:0] rsel;
      logic [2:0] sts;
      logic [2:0] msk;
      logic ce_s1;
      logic ce_s2;
      logic ce_d;
      logic am_s1;
      logic am_s2;
      logic am_d;
      logic fm_s1;
      logic fm_s2;
      logic fm_d;
      logic xt_s1;
      logic xt_s2;
      logic xt_d;
      logic [11:0] prog;
      logic [4:0] swal;
      logic [5:0] pre;
      logic [12:0] refc;
      logic fn_p;
      logic ref_p;
      logic up;
      logic dn;
      logic ce_rst;
      logic [7:0] rdata;
   } ppd_state_t;

   // Crystal edges per reference period, 4.5 MHz over the selected rate
   function automatic logic [12:0] ppd_ref_div(input logic [3:0] sel);
      logic [12:0] d;
      d = 13'h1194;
      case (sel)
         4'h1: d = 13'h05DC;
         4'h2: d = 13'h0384;
         4'h3: d = 13'h02D0;
         4'h4: d = 13'h01F4;
         4'h5: d = 13'h01C2;
         4'h6: d = 13'h0168;
         4'h7: d = 13'h00B4;
         4'h8: d = 13'h005A;
         4'h9: d = 13'h002D;
         default: d = 13'h1194;
      endcase
      return d;
   endfunction : ppd_ref_div
endpackage : ppd_pkg

//--- src/ppd_top.sv
// Programmable divider, reference generator and phase outputs
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ppd_top
   import ppd_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_chip_enable,
   input wire logic i_am_vco_input,
   input wire logic i_fm_vco_input,
   input wire logic i_xtal_clk,
   input wire logic i_if_count_done,
   output logic o_am_pull_low,
   output logic o_fm_pull_low,
   output logic o_fn_pulse,
   output logic o_ref_pulse,
   output logic o_error_out_0,
   output logic o_error_out_0_oe_n,
   output logic o_error_out_1,
   output logic o_error_out_1_oe_n,
   output logic o_ce_reset,
   output logic o_irq
);
   ppd_state_t st_r;
   ppd_state_t st_nxt;

   always_comb begin
      logic ce_rise;
      logic ce_fall;
      logic vco_edge;
      logic xt_edge;
      logic method;
      logic en_now;
      logic mode_wr;
      logic tick;
      logic [11:0] load_n;
      logic [4:0] load_m;
      ce_rise = 1'b0;
      ce_fall = 1'b0;
      vco_edge = 1'b0;
      xt_edge = 1'b0;
      method = 1'b0;
      en_now = 1'b0;
      mode_wr = 1'b0;
      tick = 1'b0;
      load_n = 12'h000;
      load_m = 5'h00;
      st_nxt = st_r;
      st_nxt.fn_p = 1'b0;
      st_nxt.ref_p = 1'b0;
      st_nxt.ce_rst = 1'b0;
      st_nxt.rdata = 8'h00;
      // ----------------------------------------
      // Pin synchronisers
      // ----------------------------------------
      st_nxt.ce_s1 = i_chip_enable;
      st_nxt.ce_s2 = st_r.ce_s1;
      st_nxt.ce_d = st_r.ce_s2;
      st_nxt.am_s1 = i_am_vco_input;
      st_nxt.am_s2 = st_r.am_s1;
      st_nxt.am_d = st_r.am_s2;
      st_nxt.fm_s1 = i_fm_vco_input;
      st_nxt.fm_s2 = st_r.fm_s1;
      st_nxt.fm_d = st_r.fm_s2;
      st_nxt.xt_s1 = i_xtal_clk;
      st_nxt.xt_s2 = st_r.xt_s1;
      st_nxt.xt_d = st_r.xt_s2;
      ce_rise = st_r.ce_s2 & ~st_r.ce_d;
      ce_fall = ~st_r.ce_s2 & st_r.ce_d;
      xt_edge = st_r.xt_s2 & ~st_r.xt_d;
      method = st_r.mode[PPD_MB_METHOD];
      // Only the selected input counts; the other is pulled low
      vco_edge = method ? (st_r.fm_s2 & ~st_r.fm_d) : (st_r.am_s2 & ~st_r.am_d);
      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      mode_wr = i_wr && (i_addr == PPD_A_MODE);
      if (mode_wr) begin
         // Pending bits: a written 0 clears, a written 1 is ignored
         st_nxt.mode = {i_wdata[7:5], 1'b0, i_wdata[PPD_MB_IFEN],
            st_r.mode[PPD_MB_IFPND] & i_wdata[PPD_MB_IFPND], i_wdata[PPD_MB_CEEN],
            st_r.mode[PPD_MB_CEPND] & i_wdata[PPD_MB_CEPND]};
      end else if (i_wr && (i_addr == PPD_A_DLO)) begin
         st_nxt.dlo = i_wdata;
      end else if (i_wr && (i_addr == PPD_A_DHI)) begin
         st_nxt.dhi = i_wdata;
      end else if (i_wr && (i_addr == PPD_A_RSEL)) begin
         st_nxt.rsel = i_wdata[3:0];
      end else if (i_wr && (i_addr == PPD_A_STS)) begin
         st_nxt.sts = st_r.sts & ~i_wdata[2:0];
      end else if (i_wr && (i_addr == PPD_A_MSK)) begin
         st_nxt.msk = i_wdata[2:0];
      end
      // ----------------------------------------
      // Events; set wins over a same-cycle clear
      // ----------------------------------------
      if (ce_fall) begin
         st_nxt.sts[PPD_SB_CEFALL] = 1'b1;
         if (st_nxt.mode[PPD_MB_CEEN]) begin
            st_nxt.mode[PPD_MB_CEPND] = 1'b1;
         end
      end
      if (i_if_count_done) begin
         st_nxt.sts[PPD_SB_IFC] = 1'b1;
         if (st_nxt.mode[PPD_MB_IFEN]) begin
            st_nxt.mode[PPD_MB_IFPND] = 1'b1;
         end
      end
      if (ce_rise) begin
         st_nxt.sts[PPD_SB_CERISE] = 1'b1;
         st_nxt.ce_rst = 1'b1;
      end
      // ----------------------------------------
      // Programmable divider
      // ----------------------------------------
      load_n = {st_r.dhi, st_r.dlo[7:4]};
      // Swallow count unused in direct mode, so it is held at zero
      load_m = st_nxt.mode[PPD_MB_METHOD] ? {st_r.dlo[3:0], st_nxt.mode[PPD_MB_NF]} : 5'h00;
      en_now = st_nxt.mode[PPD_MB_ENABLE] && st_r.ce_s2;
      case (st_r.run)
         PPD_IDLE: begin
            st_nxt.pre = 6'h00;
            if (en_now) begin
               st_nxt.run = PPD_RUN;
               st_nxt.prog = load_n;
               st_nxt.swal = load_m;
            end
         end
         PPD_RUN: begin
            if (!en_now) begin
               st_nxt.run = PPD_IDLE;
            end else if (mode_wr) begin
               // A mode write that keeps the divider enabled restarts the count from fresh data
               st_nxt.prog = load_n;
               st_nxt.swal = load_m;
               st_nxt.pre = 6'h00;
            end else if (vco_edge) begin
               if (!method) begin
                  tick = 1'b1;
               end else if (st_r.pre == ((st_r.swal != 5'h00) ? PPD_PRE_LAST33 : PPD_PRE_LAST32)) begin
                  st_nxt.pre = 6'h00;
                  tick = 1'b1;
               end else begin
                  st_nxt.pre = st_r.pre + 6'h01;
               end
               if (tick) begin
                  if (st_r.prog <= 12'h001) begin
                     // Terminal count: fresh data picked up here and on a mode write
                     st_nxt.prog = load_n;
                     st_nxt.swal = load_m;
                     st_nxt.fn_p = 1'b1;
                  end else begin
                     st_nxt.prog = st_r.prog - 12'h001;
                     if (st_r.swal != 5'h00) begin
                        st_nxt.swal = st_r.swal - 5'h01;
                     end
                  end
               end
            end
         end
         default: begin
            st_nxt.run = PPD_IDLE;
         end
      endcase
      // ----------------------------------------
      // Reference generator
      // ----------------------------------------
      if (!en_now) begin
         st_nxt.refc = 13'h0000;
      end else if (xt_edge) begin
         if (st_r.refc >= ppd_ref_div(st_r.rsel) - 13'h0001) begin
            st_nxt.refc = 13'h0000;
            st_nxt.ref_p = 1'b1;
         end else begin
            st_nxt.refc = st_r.refc + 13'h0001;
         end
      end
      // ----------------------------------------
      // Phase comparator
      // ----------------------------------------
      if (!en_now) begin
         st_nxt.up = 1'b0;
         st_nxt.dn = 1'b0;
      end else begin
         st_nxt.up = st_r.up | st_nxt.ref_p;
         st_nxt.dn = st_r.dn | st_nxt.fn_p;
         if (st_nxt.up && st_nxt.dn) begin
            // Both edges seen: phases match, release the pin
            st_nxt.up = 1'b0;
            st_nxt.dn = 1'b0;
         end
      end
      // ----------------------------------------
      // Register reads
      // ----------------------------------------
      if (i_rd) begin
         if (i_addr == PPD_A_MODE) begin
            st_nxt.rdata = {st_r.mode[7:5], 1'b0, st_r.mode[3:0]};
         end else if (i_addr == PPD_A_DLO) begin
            st_nxt.rdata = st_r.dlo;
         end else if (i_addr == PPD_A_DHI) begin
            st_nxt.rdata = st_r.dhi;
         end else if (i_addr == PPD_A_RSEL) begin
            st_nxt.rdata = {3'h0, st_r.ce_s2, st_r.rsel};
         end else if (i_addr == PPD_A_STS) begin
            st_nxt.rdata = {5'h00, st_r.sts};
         end else if (i_addr == PPD_A_MSK) begin
            st_nxt.rdata = {5'h00, st_r.msk};
         end else begin
            st_nxt.rdata = 8'h00;
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_r <= '0;
         st_r.run <= PPD_IDLE;
         st_r.mode <= PPD_MODE_RST;
         st_r.rsel <= PPD_RSEL_RST;
         st_r.msk <= PPD_MSK_RST;
         // Division data survive reset; no defined power-on value
         st_r.dlo <= st_r.dlo;
         st_r.dhi <= st_r.dhi;
         st_r.ce_s1 <= st_nxt.ce_s1;
         st_r.ce_s2 <= st_nxt.ce_s2;
         st_r.ce_d <= st_nxt.ce_d;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_rdata = st_r.rdata;
   assign o_am_pull_low = st_r.mode[PPD_MB_METHOD];
   assign o_fm_pull_low = ~st_r.mode[PPD_MB_METHOD];
   assign o_fn_pulse = st_r.fn_p;
   assign o_ref_pulse = st_r.ref_p;
   // Low when reference leads, high when divided leads, floating otherwise
   assign o_error_out_0 = st_r.dn;
   assign o_error_out_0_oe_n = ~(st_r.up | st_r.dn);
   assign o_error_out_1 = st_r.dn;
   assign o_error_out_1_oe_n = ~(st_r.up | st_r.dn);
   assign o_ce_reset = st_r.ce_rst;
   assign o_irq = |(st_r.sts & st_r.msk);
endmodule : ppd_top
`default_nettype wire

//--- tb/ppd_assertions.sv
// Concurrent checks on the divider's top-level ports
`timescale 1ns/10ps
`default_nettype none
module ppd_assertions
   import ppd_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_chip_enable,
   input wire logic o_am_pull_low,
   input wire logic o_fm_pull_low,
   input wire logic o_fn_pulse,
   input wire logic o_ref_pulse,
   input wire logic o_error_out_0,
   input wire logic o_error_out_1,
   input wire logic o_error_out_0_oe_n,
   input wire logic o_error_out_1_oe_n,
   input wire logic o_ce_reset,
   input wire logic o_irq
);
   // ----
   // Port relations
   // ----
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   chk_pull_method:
      assert property (i_wr && i_addr == PPD_A_MODE |->
         ##2 o_am_pull_low == $past(i_wdata[PPD_MB_METHOD], 2)) else $error("pull follows method");
   chk_pull_pair:
      assert property (o_am_pull_low != o_fm_pull_low) else $error("pulls not complementary");
   chk_fn_single:
      assert property (o_fn_pulse |=> !o_fn_pulse) else $error("divided pulse too long");
   chk_ref_single:
      assert property ($rose(o_ref_pulse) |=> $fell(o_ref_pulse)) else $error("ref pulse too long");
   chk_ce_stops:
      assert property (!i_chip_enable [*6] |-> o_error_out_0_oe_n && o_error_out_1_oe_n
         && !o_fn_pulse && !o_ref_pulse) else $error("activity with chip enable low");
   chk_stop_quiet:
      assert property (i_wr && i_addr == PPD_A_MODE && !i_wdata[PPD_MB_ENABLE] |->
         ##2 !o_fn_pulse [*6]) else $error("pulse after stop");
   chk_ce_rise:
      assert property ($rose(i_chip_enable) |-> ##[2:5] o_ce_reset) else $error("no ce reset");
   chk_irq_mask:
      assert property (i_wr && i_addr == PPD_A_MSK && i_wdata == 8'h00 |=> !o_irq)
         else $error("irq with all masked");
   chk_err_pins:
      assert property (o_error_out_0_oe_n == o_error_out_1_oe_n && o_error_out_0 == o_error_out_1)
         else $error("error pins differ");
endmodule : ppd_assertions
`default_nettype wire

//--- tb/ppd_vco_model.sv
// Behavioural oscillator on both divider input pins
`timescale 1ns/10ps
`default_nettype none
module ppd_vco_model #(
   parameter real HALF = 25.0
) (
   input wire logic i_am_pull_low,
   input wire logic i_fm_pull_low,
   output logic o_am_vco_input,
   output logic o_fm_vco_input
);
   logic osc = 1'b0;
   always #(HALF) osc = ~osc;
   // A pulled pin shows no swing, so a wrong pin choice starves the divider
   assign o_am_vco_input = osc & ~i_am_pull_low;
   assign o_fm_vco_input = osc & ~i_fm_pull_low;
endmodule : ppd_vco_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the programmable divider
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ppd_pkg::*;
   logic i_mclk = 1'b0;
   logic i_xtal_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_chip_enable = 1'b1;
   logic i_if_count_done = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] o_rdata;
   logic i_am_vco_input, i_fm_vco_input, o_am_pull_low, o_fm_pull_low, o_fn_pulse;
   logic o_ref_pulse, o_error_out_0, o_error_out_0_oe_n, o_error_out_1, o_error_out_1_oe_n;
   logic o_ce_reset, o_irq;
   wire logic vs = i_am_vco_input | i_fm_vco_input;
   int fails = 0;
   int total_checks = 0;
   int ec = 0;
   int xc = 0;
   int fc = 0;
   int a;
   ppd_top uut (.i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_chip_enable,
      .i_am_vco_input, .i_fm_vco_input, .i_xtal_clk, .i_if_count_done, .o_am_pull_low,
      .o_fm_pull_low, .o_fn_pulse, .o_ref_pulse, .o_error_out_0, .o_error_out_0_oe_n,
      .o_error_out_1, .o_error_out_1_oe_n, .o_ce_reset, .o_irq);
   ppd_vco_model #(.HALF(25.0)) vco (.i_am_pull_low(o_am_pull_low),
      .i_fm_pull_low(o_fm_pull_low), .o_am_vco_input(i_am_vco_input),
      .o_fm_vco_input(i_fm_vco_input));
   // ----
   // Clocks and edge counters
   // ----
   always #2 i_mclk = ~i_mclk;
   always #111.11 i_xtal_clk = ~i_xtal_clk;
   // Slow VCO keeps counter snapshots clear of the sync latency
   always @(posedge vs) ec++;
   always @(posedge i_xtal_clk) xc++;
   always @(posedge i_mclk) if (o_fn_pulse === 1'b1) fc++;
   // ----
   // Tasks
   // ----
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(input logic [2:0] ad, input logic [7:0] d);
      i_addr <= ad;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      // One idle edge, so a following call never re-drives the strobe in this step
      @(posedge i_mclk);
   endtask : wr
   task automatic rd(input logic [2:0] ad, input logic [7:0] e);
      i_addr <= ad;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 cmp(o_rdata, e);
      @(posedge i_mclk);
   endtask : rd
   task automatic ck_irq(input logic e);
      #1 cmp(o_irq, e);
      @(posedge i_mclk);
   endtask : ck_irq
   task automatic wp(input bit r);
      int k;
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while ((r ? o_ref_pulse : o_fn_pulse) !== 1'b1 && k < 20000);
      if (k >= 20000) begin
         fails++;
         test_done();
      end
   endtask : wp
   task automatic meas(input bit r, input int e);
      wp(r);
      a = r ? xc : ec;
      wp(r);
      cmp((r ? xc : ec) - a, e);
   endtask : meas
   // ----
   // Sequence
   // ----
   initial begin
      repeat (16) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
      rd(PPD_A_MODE, PPD_MODE_RST);
      rd(PPD_A_RSEL, 8'h10);
      rd(PPD_A_MSK, 8'h00);
      rd(3'h6, 8'h00);
      $display("done: register defaults");
      wr(PPD_A_DHI, 8'h01);
      wr(PPD_A_DLO, 8'h00);
      wr(PPD_A_RSEL, 8'h09);
      wr(PPD_A_MODE, 8'h40);
      meas(1'b0, 16);
      meas(1'b1, 45);
      wp(1'b0);
      a = ec;
      wr(PPD_A_DLO, 8'h40);
      wp(1'b0);
      cmp(ec - a, 16);
      meas(1'b0, 20);
      $display("done: direct division");
      wr(PPD_A_DHI, 8'h02);
      wr(PPD_A_DLO, 8'h0B);
      wr(PPD_A_MODE, 8'hE0);
      meas(1'b0, 1047);
      $display("done: swallow division");
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
      rd(PPD_A_DLO, 8'h0B);
      rd(PPD_A_DHI, 8'h02);
      a = fc;
      repeat (400) @(posedge i_mclk);
      cmp(fc - a, 0);
      $display("done: reset and stop");
      wr(PPD_A_STS, 8'h07);
      wr(PPD_A_MODE, 8'h08);
      i_if_count_done <= 1'b1;
      @(posedge i_mclk);
      i_if_count_done <= 1'b0;
      rd(PPD_A_MODE, 8'h0C);
      ck_irq(1'b0);
      wr(PPD_A_MSK, 8'h02);
      ck_irq(1'b1);
      wr(PPD_A_MSK, 8'h00);
      ck_irq(1'b0);
      wr(PPD_A_MODE, 8'h08);
      rd(PPD_A_MODE, 8'h08);
      wr(PPD_A_STS, 8'h02);
      $display("done: interrupts");
      wr(PPD_A_DLO, 8'h00);
      wr(PPD_A_MODE, 8'h42);
      wp(1'b0);
      i_chip_enable <= 1'b0;
      repeat (8) @(posedge i_mclk);
      rd(PPD_A_MODE, 8'h43);
      rd(PPD_A_RSEL, 8'h00);
      rd(PPD_A_STS, 8'h01);
      a = fc;
      repeat (400) @(posedge i_mclk);
      cmp(fc - a, 0);
      cmp({o_error_out_0_oe_n, o_error_out_1_oe_n}, 2'b11);
      i_chip_enable <= 1'b1;
      repeat (8) @(posedge i_mclk);
      rd(PPD_A_STS, 8'h05);
      wp(1'b0);
      wr(PPD_A_MODE, 8'h00);
      a = fc;
      repeat (800) @(posedge i_mclk);
      cmp(fc - a, 0);
      $display("done: chip enable");
      test_done();
   end
endmodule : tb
bind ppd_top ppd_assertions chk (.i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_chip_enable,
   .o_am_pull_low, .o_fm_pull_low, .o_fn_pulse, .o_ref_pulse, .o_error_out_0, .o_error_out_1,
   .o_error_out_0_oe_n, .o_error_out_1_oe_n, .o_ce_reset, .o_irq);
`default_nettype wire
